/* File: rtl/epv_pkg.sv */
package epv_pkg;

    // Exception numbers
    localparam logic [5:0] EXC_RESET = 6'h01;
    localparam logic [5:0] EXC_NMI = 6'h02;
    localparam logic [5:0] EXC_FAULT = 6'h03;
    localparam logic [5:0] EXC_SUPER_CALL = 6'h0b;
    localparam logic [5:0] EXC_DEFER = 6'h0e;
    localparam logic [5:0] EXC_TICK = 6'h0f;
    localparam logic [5:0] EXC_IRQ0 = 6'h10;
    localparam int NUM_EXC = 48;
    localparam int IRQ_MAX = 32;

    // Core register indices
    localparam logic [3:0] IDX_SP = 4'hd;
    localparam logic [3:0] IDX_LR = 4'he;
    localparam logic [3:0] IDX_PC = 4'hf;
    localparam logic [31:0] PC_READ_OFS = 32'h0000_0004;

    // Effective priority: value + 3, so fixed levels fit 3 bits unsigned
    localparam logic [2:0] PRI_NMI = 3'h1;
    localparam logic [2:0] PRI_FAULT = 3'h2;
    localparam logic [2:0] PRI_CFG_BASE = 3'h3;
    localparam logic [2:0] PRI_NONE = 3'h7;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATE = 8'h04;
    localparam logic [7:0] OFS_VTBL = 8'h08;
    localparam logic [7:0] OFS_SYSPRI = 8'h0c;
    localparam logic [7:0] OFS_EN_SET = 8'h10;
    localparam logic [7:0] OFS_EN_CLR = 8'h14;
    localparam logic [7:0] OFS_PEND_SET = 8'h18;
    localparam logic [7:0] OFS_PEND_CLR = 8'h1c;
    localparam logic [7:0] OFS_IPRI_LO = 8'h20;
    localparam logic [7:0] OFS_IPRI_HI = 8'h24;
    localparam logic [7:0] OFS_DBG = 8'h28;

    // Field positions
    localparam int BIT_PMASK = 0;
    localparam int BIT_SSEL = 1;
    localparam int BIT_NMI_SET = 31;
    localparam int BIT_DEFER_SET = 28;
    localparam int BIT_DEFER_CLR = 27;
    localparam int BIT_TICK_SET = 26;
    localparam int BIT_TICK_CLR = 25;
    localparam int POS_PEND_NUM = 16;
    localparam logic [31:0] VTBL_MASK = 32'hffff_ff80;
    localparam logic [31:0] SP_MASK = 32'hffff_fffc;

    typedef enum logic [1:0] {
        EPV_ST_SP = 2'b00,
        EPV_ST_PC = 2'b01,
        EPV_ST_RUN = 2'b11,
        EPV_ST_VEC = 2'b10
    } epv_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } epv_bus_s;

    typedef struct packed {
        logic [5:0] num;
        logic [2:0] prio;
    } epv_pick_s;

endpackage

/* File: rtl/epv_core.sv */
`timescale 1ns/1ns
`default_nettype none

module epv_core #(
    parameter int N_IRQ = 32,
    parameter bit RELOC = 1'b1
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic local_rst_n,
    input wire epv_pkg::epv_bus_s bus,
    output logic [31:0] bus_rdata,
    input wire logic core_rd,
    input wire logic [3:0] core_rd_idx,
    output logic [31:0] core_rd_data,
    input wire logic core_wr,
    input wire logic [3:0] core_wr_idx,
    input wire logic [31:0] core_wr_data,
    input wire logic [31:0] program_counter,
    input wire logic nmi_in,
    input wire logic tick_in,
    input wire logic [epv_pkg::IRQ_MAX-1:0] irq_in,
    input wire logic fault_in,
    input wire logic supervisor_call_instruction,
    input wire logic take_ack,
    input wire logic exc_ret,
    input wire logic [5:0] exc_ret_num,
    output logic [5:0] exc_num,
    output logic take_req,
    output logic vec_req,
    output logic [31:0] vec_addr,
    input wire logic vec_valid,
    input wire logic [31:0] vec_rdata,
    output logic [31:0] handler_pc,
    output logic handler_valid,
    output logic exec_state_bit,
    output logic run
);
    import epv_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Most urgent set entry; ascending scan keeps lowest number on ties
    function automatic epv_pick_s pick(input logic [NUM_EXC-1:0] v,
                                       input logic [3*NUM_EXC-1:0] pt);
        epv_pick_s best;
        best.num = 6'h00;
        best.prio = PRI_NONE;
        for (int i = 0; i < NUM_EXC; i++) begin
            if (v[i] && (pt[3*i+:3] < best.prio)) begin
                best.num = 6'(i);
                best.prio = pt[3*i+:3];
            end
        end
        return best;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    logic sys_rst;
    logic [IRQ_MAX+1:0] sync1_q, sync2_q;
    logic [31:0] gpr_q [0:12];
    logic [31:0] lr_q, msp_q, psp_q;
    logic pmask_q, ssel_q;
    logic [31:0] vtbl_q;
    logic [5:0] sys_pri_q;
    logic [2*IRQ_MAX-1:0] ipri_q;
    logic [IRQ_MAX-1:0] irq_en_q;
    logic [NUM_EXC-1:0] pend_q, pend_d, act_q, act_d;
    logic [31:0] dbg_q;
    epv_state_e state_q;
    logic [31:0] bus_rdata_q, core_rd_q, vec_addr_q, handler_pc_q;
    logic [5:0] exc_num_q;
    logic take_q, vec_req_q, handler_valid_q, tbit_q, run_q;

    // Local reset spares debug state; general registers and pin synchronisers have no reset at all
    assign sys_rst = !nrst || !local_rst_n;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    always_ff @(posedge clock) begin
        sync1_q <= {nmi_in, tick_in, irq_in};
        sync2_q <= sync1_q;
    end

    wire nmi_hw = sync2_q[IRQ_MAX+1];
    wire tick_hw = sync2_q[IRQ_MAX];
    wire [IRQ_MAX-1:0] irq_hw = sync2_q[IRQ_MAX-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode

    wire wr_ctrl = bus.wr && (bus.addr == OFS_CTRL);
    wire wr_state = bus.wr && (bus.addr == OFS_STATE);
    wire wr_vtbl = bus.wr && (bus.addr == OFS_VTBL);
    wire wr_syspri = bus.wr && (bus.addr == OFS_SYSPRI);
    wire wr_en_set = bus.wr && (bus.addr == OFS_EN_SET);
    wire wr_en_clr = bus.wr && (bus.addr == OFS_EN_CLR);
    wire wr_pend_set = bus.wr && (bus.addr == OFS_PEND_SET);
    wire wr_pend_clr = bus.wr && (bus.addr == OFS_PEND_CLR);
    wire wr_ipri_lo = bus.wr && (bus.addr == OFS_IPRI_LO);
    wire wr_ipri_hi = bus.wr && (bus.addr == OFS_IPRI_HI);
    wire wr_dbg = bus.wr && (bus.addr == OFS_DBG);
    wire sw_nmi = wr_state && bus.wdata[BIT_NMI_SET];
    wire sw_defer_set = wr_state && bus.wdata[BIT_DEFER_SET];
    wire sw_defer_clr = wr_state && bus.wdata[BIT_DEFER_CLR];
    wire sw_tick_set = wr_state && bus.wdata[BIT_TICK_SET];
    wire sw_tick_clr = wr_state && bus.wdata[BIT_TICK_CLR];
    wire [IRQ_MAX-1:0] irq_impl = IRQ_MAX'((64'h1 << N_IRQ) - 64'h1);

    ////////////////////////////////////////////////////////////////////////
    // Priority table and selection

    logic [3*NUM_EXC-1:0] pri_tab;
    always_comb begin
        pri_tab = '1; // Reserved numbers never win
        pri_tab[3*EXC_NMI+:3] = PRI_NMI;
        pri_tab[3*EXC_FAULT+:3] = PRI_FAULT;
        pri_tab[3*EXC_SUPER_CALL+:3] = PRI_CFG_BASE + {1'b0, sys_pri_q[1:0]};
        pri_tab[3*EXC_DEFER+:3] = PRI_CFG_BASE + {1'b0, sys_pri_q[3:2]};
        pri_tab[3*EXC_TICK+:3] = PRI_CFG_BASE + {1'b0, sys_pri_q[5:4]};
        for (int i = 0; i < IRQ_MAX; i++) begin
            pri_tab[3*(16+i)+:3] = PRI_CFG_BASE + {1'b0, ipri_q[2*i+:2]};
        end
    end

    // Fixed and system exceptions always enabled, externals by mask
    wire [NUM_EXC-1:0] en_all = {irq_en_q & irq_impl, 16'hc80c};
    wire epv_pick_s best = pick(pend_q & en_all, pri_tab);
    wire epv_pick_s act_best = pick(act_q, pri_tab);
    wire [2:0] exec_pri = (pmask_q && (act_best.prio > PRI_CFG_BASE)) ?
                          PRI_CFG_BASE : act_best.prio;
    wire beats = best.prio < exec_pri;
    wire in_handler = |act_q;

    ////////////////////////////////////////////////////////////////////////
    // Pending and active next state; pending sets win over clears, an active return clear wins over an accept

    wire vec_fault = (state_q != EPV_ST_SP) && (state_q != EPV_ST_RUN) &&
                     vec_valid && !vec_rdata[0];
    wire ack_ok = take_ack && (state_q == EPV_ST_RUN);
    always_comb begin
        pend_d = pend_q;
        act_d = act_q;
        if (ack_ok) begin
            pend_d[exc_num_q] = 1'b0;
            act_d[exc_num_q] = 1'b1;
        end
        if (exc_ret) begin
            act_d[exc_ret_num] = 1'b0;
        end
        if (sw_defer_clr) begin
            pend_d[EXC_DEFER] = 1'b0;
        end
        if (sw_tick_clr) begin
            pend_d[EXC_TICK] = 1'b0;
        end
        if (wr_pend_clr) begin
            pend_d[NUM_EXC-1:16] = pend_d[NUM_EXC-1:16] & ~bus.wdata;
        end
        if (nmi_hw || sw_nmi) begin
            pend_d[EXC_NMI] = 1'b1;
        end
        if (fault_in || vec_fault) begin
            pend_d[EXC_FAULT] = 1'b1;
        end
        if (supervisor_call_instruction) begin
            pend_d[EXC_SUPER_CALL] = 1'b1;
        end
        if (sw_defer_set) begin
            pend_d[EXC_DEFER] = 1'b1;
        end
        if (tick_hw || sw_tick_set) begin
            pend_d[EXC_TICK] = 1'b1;
        end
        pend_d[NUM_EXC-1:16] = pend_d[NUM_EXC-1:16] | (irq_hw & irq_impl);
        if (wr_pend_set) begin
            pend_d[NUM_EXC-1:16] = pend_d[NUM_EXC-1:16] | (bus.wdata & irq_impl);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pend_q <= '0;
            act_q <= '0;
        end else begin
            pend_q <= pend_d;
            act_q <= act_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    wire [31:0] vtbl_d = RELOC ? (bus.wdata & VTBL_MASK) : '0;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pmask_q <= 1'b0;
            ssel_q <= 1'b0;
            vtbl_q <= '0;
            sys_pri_q <= '0;
            ipri_q <= '0;
            irq_en_q <= '0;
        end else begin
            if (wr_ctrl) begin
                pmask_q <= bus.wdata[BIT_PMASK];
            end
            if (wr_ctrl && !in_handler) begin
                ssel_q <= bus.wdata[BIT_SSEL];
            end
            if (wr_vtbl) begin
                vtbl_q <= vtbl_d;
            end
            if (wr_syspri) begin
                sys_pri_q <= bus.wdata[5:0];
            end
            if (wr_ipri_lo) begin
                ipri_q[31:0] <= bus.wdata;
            end
            if (wr_ipri_hi) begin
                ipri_q[63:32] <= bus.wdata;
            end
            if (wr_en_set || wr_en_clr) begin
                irq_en_q <= wr_en_set ? (irq_en_q | bus.wdata) : (irq_en_q & ~bus.wdata);
            end
        end
    end

    // Debug scratch survives local reset
    always_ff @(posedge clock) begin
        if (!nrst) begin
            dbg_q <= '0;
        end else if (wr_dbg) begin
            dbg_q <= bus.wdata;
        end
    end

    // Read mux
    wire [31:0] state_rd = {nmi_hw | pend_q[EXC_NMI], 2'b00, pend_q[EXC_DEFER], 1'b0,
                            pend_q[EXC_TICK], 4'h0, best.num, 10'h000, act_best.num};
    logic [31:0] rd_mux;
    always_comb begin
        case (bus.addr)
            OFS_CTRL: rd_mux = {30'h0, ssel_q, pmask_q};
            OFS_STATE: rd_mux = state_rd;
            OFS_VTBL: rd_mux = vtbl_q;
            OFS_SYSPRI: rd_mux = {26'h0, sys_pri_q};
            OFS_EN_SET, OFS_EN_CLR: rd_mux = irq_en_q & irq_impl;
            OFS_PEND_SET, OFS_PEND_CLR: rd_mux = pend_q[NUM_EXC-1:16];
            OFS_IPRI_LO: rd_mux = ipri_q[31:0];
            OFS_IPRI_HI: rd_mux = ipri_q[63:32];
            OFS_DBG: rd_mux = dbg_q;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus_rdata_q <= '0;
        end else if (bus.rd) begin
            bus_rdata_q <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core register file

    wire [31:0] sp_cur = ssel_q ? psp_q : msp_q;
    wire [31:0] core_mux = (core_rd_idx == IDX_PC) ? (program_counter + PC_READ_OFS) :
                           (core_rd_idx == IDX_LR) ? lr_q :
                           (core_rd_idx == IDX_SP) ? sp_cur : gpr_q[core_rd_idx];
    wire wr_sp = core_wr && (core_wr_idx == IDX_SP);
    wire load_sp = (state_q == EPV_ST_SP) && vec_valid;

    always_ff @(posedge clock) begin
        if (core_wr && (core_wr_idx < IDX_SP)) begin
            gpr_q[core_wr_idx] <= core_wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lr_q <= '0;
            msp_q <= '0;
            psp_q <= '0;
            core_rd_q <= '0;
        end else begin
            if (core_wr && (core_wr_idx == IDX_LR)) begin
                lr_q <= core_wr_data;
            end
            if (load_sp) begin
                msp_q <= vec_rdata;
            end else if (wr_sp && !ssel_q) begin
                msp_q <= core_wr_data & SP_MASK;
            end
            if (wr_sp && ssel_q) begin
                psp_q <= core_wr_data & SP_MASK;
            end
            if (core_rd) begin
                core_rd_q <= core_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Vector sequencer

    wire [31:0] vec_of_num = vtbl_q + {24'h0, exc_num_q, 2'b00};
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= EPV_ST_SP;
            vec_req_q <= 1'b1;
            vec_addr_q <= '0;
            handler_pc_q <= '0;
            handler_valid_q <= 1'b0;
            tbit_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            handler_valid_q <= 1'b0;
            case (state_q)
                EPV_ST_SP: begin
                    vec_addr_q <= vtbl_q;
                    if (vec_valid) begin
                        state_q <= EPV_ST_PC;
                        vec_addr_q <= vtbl_q + {24'h0, EXC_RESET, 2'b00};
                    end
                end
                EPV_ST_PC, EPV_ST_VEC: begin
                    if (vec_valid) begin
                        state_q <= EPV_ST_RUN;
                        vec_req_q <= 1'b0;
                        run_q <= 1'b1;
                        handler_pc_q <= {vec_rdata[31:1], 1'b0};
                        tbit_q <= vec_rdata[0];
                        handler_valid_q <= 1'b1;
                    end
                end
                EPV_ST_RUN: begin
                    if (ack_ok) begin
                        state_q <= EPV_ST_VEC;
                        vec_req_q <= 1'b1;
                        vec_addr_q <= vec_of_num;
                    end
                end
                default: state_q <= EPV_ST_SP;
            endcase
        end
    end

    // Selection to the core
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            exc_num_q <= '0;
            take_q <= 1'b0;
        end else begin
            exc_num_q <= best.num;
            take_q <= (state_q == EPV_ST_RUN) && !ack_ok && beats;
        end
    end

    assign bus_rdata = bus_rdata_q;
    assign core_rd_data = core_rd_q;
    assign exc_num = exc_num_q;
    assign take_req = take_q;
    assign vec_req = vec_req_q;
    assign vec_addr = vec_addr_q;
    assign handler_pc = handler_pc_q;
    assign handler_valid = handler_valid_q;
    assign exec_state_bit = tbit_q;
    assign run = run_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_read_pc_offset: assert property (core_rd && core_rd_idx == IDX_PC |=>
        core_rd_data == $past(program_counter) + PC_READ_OFS) else $error("pc read wrong");
    a_sp_write_align: assert property (wr_sp && !ssel_q && !load_sp |=>
        msp_q == ($past(core_wr_data) & SP_MASK)) else $error("msp write wrong");
    a_reset_sp_load: assert property (load_sp |=> msp_q == $past(vec_rdata)
        && state_q == EPV_ST_PC) else $error("reset sp load wrong");
    a_vec_bit_fault: assert property (vec_fault |=> pend_q[EXC_FAULT]
        && !exec_state_bit) else $error("vector bit fault missing");
    a_fixed_base_raz: assert property (bus.rd && bus.addr == OFS_VTBL |=>
        bus_rdata[6:0] == 7'h0 && (RELOC || bus_rdata == 32'h0))
        else $error("table base not aligned or not zero");
    a_nmi_wins_take: assert property ($past(pend_q[EXC_NMI]) && take_req
        |-> exc_num == EXC_NMI) else $error("nmi not chosen");
    a_call_pends: assert property (supervisor_call_instruction |=>
        pend_q[EXC_SUPER_CALL] || $past(ack_ok)) else $error("supervisor call not pended");
    a_defer_sw_only: assert property ($rose(pend_q[EXC_DEFER]) |->
        $past(sw_defer_set)) else $error("deferred pended by hardware");
    a_take_beats_exec: assert property (take_req |-> $past(best.prio) <
        $past(exec_pri)) else $error("take without preemption");
    a_mask_blocks_cfg: assert property (pmask_q && $past(pmask_q) && take_req |->
        $past(best.prio) < PRI_CFG_BASE) else $error("mask ignored");

    c_irq_taken: cover property (take_req && exc_num >= EXC_IRQ0 ##1 take_ack);
    c_reset_done: cover property (state_q == EPV_ST_PC ##[1:20] run);
    c_vec_fault: cover property (vec_fault ##1 pend_q[EXC_FAULT]);
    c_nested: cover property ($countones(act_q) == 2);

endmodule

`default_nettype wire

/* File: testbench/epv_vec_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Vector table memory, answering fetches alternately fast and slow
module epv_vec_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic vec_req,
    input wire logic [31:0] vec_addr,
    output logic vec_valid,
    output logic [31:0] vec_rdata
);
    logic [1:0] wait_q;
    logic slow_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Word 0 is the stack top, every handler entry has bit 0 set but one
    function automatic logic [31:0] word(input logic [31:0] a);
        return (a == 32'h0) ? 32'h2000_0ff0 : ({16'h0001, a[15:0]} | (a[9:0] != 10'h050));
    endfunction
    // Idle data toggles so a stale word never looks valid
    always_ff @(posedge clock) begin
        if (!nrst || !vec_req || vec_valid) begin
            wait_q <= 2'h0;
            vec_valid <= 1'b0;
            slow_q <= slow_q & nrst;
            vec_rdata <= nrst ? ~vec_rdata : 32'h5a5a_a5a5;
        end else if (wait_q == {slow_q, 1'b0}) begin
            vec_valid <= 1'b1;
            vec_rdata <= word(vec_addr);
            slow_q <= ~slow_q;
        end else begin
            wait_q <= wait_q + 2'h1;
            vec_rdata <= ~vec_rdata;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/epv_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module epv_tb_top;
    import epv_pkg::*;
    logic clock, nrst, local_rst_n, core_rd, core_wr, nmi_in, tick_in, fault_in, super_call;
    logic take_ack, exc_ret, take_req, vec_req, vec_valid, handler_valid, exec_state_bit, run;
    logic [3:0] core_rd_idx, core_wr_idx;
    logic [5:0] exc_ret_num, exc_num;
    logic [31:0] bus_rdata, core_rd_data, core_wr_data, program_counter, irq_in;
    logic [31:0] vec_addr, vec_rdata, handler_pc, d, v, m, base, en, pd;
    logic [63:0] pri;
    epv_bus_s bus;
    int seed = 43;
    int num_errors = 0;
    int checks = 0;
    int k;
    epv_core #(.N_IRQ(32), .RELOC(1'b1)) u_epv_core (.clock(clock), .nrst(nrst),
        .local_rst_n(local_rst_n), .bus(bus), .bus_rdata(bus_rdata), .core_rd(core_rd),
        .core_rd_idx(core_rd_idx), .core_rd_data(core_rd_data), .core_wr(core_wr),
        .core_wr_idx(core_wr_idx), .core_wr_data(core_wr_data),
        .program_counter(program_counter), .nmi_in(nmi_in), .tick_in(tick_in),
        .irq_in(irq_in), .fault_in(fault_in), .supervisor_call_instruction(super_call),
        .take_ack(take_ack), .exc_ret(exc_ret), .exc_ret_num(exc_ret_num), .exc_num(exc_num),
        .take_req(take_req), .vec_req(vec_req), .vec_addr(vec_addr), .vec_valid(vec_valid),
        .vec_rdata(vec_rdata), .handler_pc(handler_pc), .handler_valid(handler_valid),
        .exec_state_bit(exec_state_bit), .run(run));
    epv_vec_model u_epv_vec_model (.clock(clock), .nrst(nrst), .vec_req(vec_req),
        .vec_addr(vec_addr), .vec_valid(vec_valid), .vec_rdata(vec_rdata));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 100 ns period
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // Compare and report
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task stop_test;
        $display("Checks %0d, errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    function automatic logic sig(input int w);
        return w == 0 ? run : w == 1 ? take_req : w == 2 ? vec_req : handler_valid;
    endfunction
    // Bounded wait for a design flag
    task wait_hi(input int w);
        for (int i = 0; i < 60; i++) begin
            @(posedge clock);
            #1;
            if (sig(w) === 1'b1)
                return;
        end
        num_errors++;
        stop_test();
    endtask
    // Register port cycles
    task wr(input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock) bus <= '{a, wd, 1'b1, 1'b0};
        @(posedge clock) bus.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] rdv);
        @(posedge clock) bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock) bus.rd <= 1'b0;
        #1 rdv = bus_rdata;
    endtask
    // Core register port cycles
    task crw(input logic [3:0] i, input logic [31:0] wd);
        @(posedge clock) {core_wr, core_wr_idx, core_wr_data} <= {1'b1, i, wd};
        @(posedge clock) core_wr <= 1'b0;
    endtask
    task crd(input logic [3:0] i, output logic [31:0] rdv);
        @(posedge clock) {core_rd, core_rd_idx} <= {1'b1, i};
        @(posedge clock) core_rd <= 1'b0;
        #1 rdv = core_rd_data;
    endtask
    // Expected best pending external, lowest value then lowest number
    function automatic logic [5:0] best(input logic [31:0] p, input logic [63:0] pr);
        logic [5:0] b = 6'h0;
        logic [2:0] bp = 3'h7;
        for (int i = 0; i < 32; i++)
            if (p[i] && {1'b0, pr[2*i+:2]} < bp) begin
                b = 6'(16 + i);
                bp = {1'b0, pr[2*i+:2]};
            end
        return b;
    endfunction
    // Accept the shown exception and follow its vector fetch
    task take(input logic [5:0] n, input logic good);
        logic [31:0] a;
        a = base + 32'(n) * 4;
        wait_hi(1);
        chk(exc_num, n);
        @(posedge clock) take_ack <= 1'b1;
        @(posedge clock) take_ack <= 1'b0;
        wait_hi(2);
        chk(vec_addr, a);
        wait_hi(3);
        chk(handler_pc, {16'h0001, a[15:1], 1'b0});
        chk(exec_state_bit, good);
    endtask
    // Main sequence
    initial begin
        {nrst, core_rd, core_wr, nmi_in, tick_in, fault_in, super_call, take_ack, exc_ret} = '0;
        local_rst_n = 1'b1;
        bus = '0;
        {core_rd_idx, core_wr_idx, exc_ret_num, core_wr_data, program_counter, irq_in} = '0;
        base = 32'h0;
        cyc(8);
        nrst <= 1'b1;
        wait_hi(0);
        chk(handler_pc, 32'h0001_0004);
        chk(exec_state_bit, 1'b1);
        crd(IDX_SP, d);
        chk(d, 32'h2000_0ff0);
        for (k = 0; k < 5; k++) begin
            rd(k == 4 ? 8'h44 : OFS_SYSPRI + 8'(k > 0) * 8'h14 + 8'(k > 1) * 8'h04, d);
            chk(d, 32'h0);
        end
        for (k = 0; k < 15; k++) begin
            v = $random(seed);
            crw(4'(k), v);
            crd(4'(k), d);
            if (k == 13)
                m = v & SP_MASK;
            chk(d, k == 13 ? v & SP_MASK : v);
        end
        program_counter <= v;
        crd(IDX_PC, d);
        chk(d, v + PC_READ_OFS);
        wr(OFS_CTRL, 32'h2);
        crw(IDX_SP, ~v);
        crd(IDX_SP, d);
        chk(d, ~v & SP_MASK);
        wr(OFS_CTRL, 32'h0);
        crd(IDX_SP, d);
        chk(d, m);
        for (k = 0; k < 8; k++) begin
            en = k == 0 ? 32'hffff_ffff : $random(seed);
            pd = $random(seed);
            pri = k == 0 ? 64'h0 : {$random(seed), $random(seed)};
            wr(OFS_EN_CLR, 32'hffff_ffff);
            wr(OFS_PEND_CLR, 32'hffff_ffff);
            wr(OFS_IPRI_LO, pri[31:0]);
            wr(OFS_IPRI_HI, pri[63:32]);
            wr(OFS_EN_SET, en);
            wr(OFS_PEND_SET, pd);
            rd(OFS_PEND_SET, d);
            chk(d, pd);
            chk(exc_num, best(en & pd, pri));
            chk(take_req, |(en & pd));
            wr(OFS_CTRL, 32'h1);
            cyc(3);
            chk(take_req, 1'b0);
            wr(OFS_CTRL, 32'h0);
        end
        wr(OFS_EN_CLR, 32'hffff_ffff);
        wr(OFS_PEND_CLR, 32'hffff_ffff);
        for (k = BIT_TICK_SET; k <= BIT_DEFER_SET; k += 2) begin
            wr(OFS_STATE, 32'h1 << k);
            rd(OFS_STATE, d);
            chk(d[k], 1'b1);
            chk(exc_num, k == BIT_DEFER_SET ? EXC_DEFER : EXC_TICK);
            wr(OFS_STATE, 32'h1 << (k - 1));
            rd(OFS_STATE, d);
            chk(d[k], 1'b0);
        end
        v = $random(seed);
        irq_in <= v;
        cyc(5);
        rd(OFS_PEND_SET, d);
        chk(d, v);
        rd(OFS_STATE, d);
        chk(d[BIT_DEFER_SET], 1'b0);
        irq_in <= 32'h0;
        cyc(4);
        wr(OFS_PEND_CLR, 32'hffff_ffff);
        base = $random(seed) & 32'h00ff_fc00;
        wr(OFS_VTBL, base | 32'h7f);
        rd(OFS_VTBL, d);
        chk(d, base);
        wr(OFS_IPRI_LO, 32'h0000_0100);
        wr(OFS_EN_SET, 32'h10);
        wr(OFS_PEND_SET, 32'h10);
        take(6'd20, 1'b0);
        take(EXC_FAULT, 1'b1);
        wr(OFS_STATE, 32'h1 << BIT_DEFER_SET);
        @(posedge clock) super_call <= 1'b1;
        @(posedge clock) super_call <= 1'b0;
        cyc(3);
        chk(take_req, 1'b0);
        chk(exc_num, EXC_SUPER_CALL);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_STATE, 32'h1 << BIT_NMI_SET);
        take(EXC_NMI, 1'b1);
        wr(OFS_CTRL, 32'h0);
        for (k = 2; k < 4; k++) begin
            @(posedge clock) {exc_ret, exc_ret_num} <= {1'b1, 6'(k)};
            @(posedge clock) exc_ret <= 1'b0;
        end
        take(EXC_SUPER_CALL, 1'b1);
        cyc(3);
        chk(take_req, 1'b0);
        v = $random(seed);
        wr(OFS_DBG, v);
        @(posedge clock) local_rst_n <= 1'b0;
        @(posedge clock) local_rst_n <= 1'b1;
        wait_hi(0);
        rd(OFS_DBG, d);
        chk(d, v);
        rd(OFS_VTBL, d);
        chk(d, 32'h0);
        // Hardware fault, nmi and tick sources pend their exceptions
        @(posedge clock) fault_in <= 1'b1;
        @(posedge clock) fault_in <= 1'b0;
        cyc(2);
        chk(exc_num, EXC_FAULT);
        {nmi_in, tick_in} <= 2'b11;
        cyc(5);
        rd(OFS_STATE, d);
        chk(d[BIT_NMI_SET], 1'b1);
        chk(d[BIT_TICK_SET], 1'b1);
        chk(exc_num, EXC_NMI);
        {nmi_in, tick_in} <= 2'b00;
        @(posedge clock) nrst <= 1'b0;
        @(posedge clock) nrst <= 1'b1;
        wait_hi(0);
        rd(OFS_DBG, d);
        chk(d, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
